// [logic/lsh_serial_ctrl.sv]
// serial command port and mode control for the line interface
`timescale 1ns/10ps
`default_nettype none
module lsh_serial_ctrl
    import lsh_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hostMode,
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOutEnN,
    input wire logic mute_on_loss_en,
    input wire logic register_reset_n,
    input wire lsh_rx_t rxIn,
    output logic [LSH_CHANNELS-1:0] rx_pos_data_out,
    output logic [LSH_CHANNELS-1:0] rx_neg_data_out,
    output lsh_cfg_t cfgOut
);
    ////////////////////////////////////////////////////////////////////
    // link side: serial clock domain, shifter and read output reset by chip select
    typedef enum logic [1:0] {
        LSH_IDLE = 2'b00,
        LSH_HDR = 2'b01,
        LSH_DATA = 2'b11,
        LSH_DONE = 2'b10
    } lsh_state_t;

    lsh_state_t state_q;
    logic [LSH_CNT_W-1:0] bitCnt_q;
    logic [LSH_ADDR_W:0] hdr_q;
    logic [LSH_DATA_W-1:0] wdata_q;
    logic [LSH_DATA_W-1:0] rdShift_q;
    logic sdo_q;
    logic sdoEnN_q;
    logic wrTog_q;
    logic [LSH_ADDR_W-1:0] wrAddrL_q;
    logic [LSH_DATA_W-1:0] wrDataL_q;
    logic [LSH_DATA_W-1:0] regs_q [LSH_REGS];
    logic [LSH_ADDR_W-1:0] hdrAddr;

    assign hdrAddr = hdr_q[LSH_ADDR_W-1:0];

    // chip select high clears the shifter asynchronously
    // the link clock is idle during reset, so reset acts on its edge here
    always_ff @(posedge serialClk or posedge chipSelN or posedge rst) begin
        if (chipSelN || rst) begin
            state_q <= LSH_IDLE;
            bitCnt_q <= '0;
            hdr_q <= '0;
            wdata_q <= '0;
        end else begin
            // capture on rising edge
            unique case (state_q)
                LSH_IDLE: begin
                    hdr_q <= {hdr_q[LSH_ADDR_W-1:0], serialDataIn};
                    bitCnt_q <= 4'h1;
                    state_q <= LSH_HDR;
                end
                LSH_HDR: begin
                    hdr_q <= {hdr_q[LSH_ADDR_W-1:0], serialDataIn};
                    bitCnt_q <= bitCnt_q + 4'h1;
                    if (bitCnt_q == 4'(LSH_ADDR_W))
                        state_q <= LSH_DATA;
                end
                LSH_DATA: begin
                    wdata_q <= {wdata_q[LSH_DATA_W-2:0], serialDataIn};
                    bitCnt_q <= bitCnt_q + 4'h1;
                    if (bitCnt_q == 4'(LSH_FRAME_BITS - 1))
                        state_q <= LSH_DONE;
                end
                LSH_DONE: begin
                    bitCnt_q <= bitCnt_q;
                end
            endcase
        end
    end

    // completed write publishes address and data on the same edge as the toggle
    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            wrTog_q <= 1'b0;
            wrAddrL_q <= '0;
            wrDataL_q <= '0;
        end else if (!chipSelN && state_q == LSH_DATA
                && bitCnt_q == 4'(LSH_FRAME_BITS - 1)
                && hdr_q[LSH_ADDR_W] != LSH_RW_READ) begin
            wrAddrL_q <= hdrAddr;
            wrDataL_q <= {wdata_q[LSH_DATA_W-2:0], serialDataIn};
            wrTog_q <= ~wrTog_q;
        end
    end

    // read data launched on falling edges; released when select goes high
    always_ff @(negedge serialClk or posedge chipSelN or posedge rst) begin
        if (chipSelN || rst) begin
            rdShift_q <= '0;
            sdo_q <= 1'b0;
            sdoEnN_q <= 1'b1;
        end else if (state_q == LSH_DATA && bitCnt_q == 4'(LSH_ADDR_W + 1)
                && hdr_q[LSH_ADDR_W] == LSH_RW_READ) begin
            // addressed register read straight from the bank
            rdShift_q <= {regs_q[hdrAddr[2:0]][LSH_DATA_W-2:0], 1'b0};
            sdo_q <= regs_q[hdrAddr[2:0]][LSH_DATA_W-1];
            sdoEnN_q <= 1'b0;
        end else if (state_q == LSH_DATA && !sdoEnN_q) begin
            rdShift_q <= {rdShift_q[LSH_DATA_W-2:0], 1'b0};
            sdo_q <= rdShift_q[LSH_DATA_W-1];
        end else begin
            sdoEnN_q <= 1'b1;
        end
    end

    assign serialDataOut = sdo_q;
    assign serialDataOutEnN = sdoEnN_q;

    ////////////////////////////////////////////////////////////////////
    // crossing into the system clock
    logic wrTogS;
    logic wrTogOld_q;
    logic [3:0] pinSync;
    logic muteS, rxOffS, clkInvS, regRstNS;

    lsh_sync2 #(.W(1), .INIT(1'b0)) uTog (
        .clk(sys_clk),
        .rst(rst),
        .din(wrTog_q),
        .dout(wrTogS)
    );

    // mute pin defaults low, register reset high
    lsh_sync2 #(.W(4), .INIT(4'h8)) uPins (
        .clk(sys_clk),
        .rst(rst),
        .din({register_reset_n, serialClk, chipSelN, mute_on_loss_en}),
        .dout(pinSync)
    );

    assign muteS = pinSync[0];
    assign rxOffS = pinSync[2];
    assign regRstNS = pinSync[3];
    assign clkInvS = pinSync[3];

    always_ff @(posedge sys_clk) begin
        if (rst)
            wrTogOld_q <= 1'b0;
        else
            wrTogOld_q <= wrTogS;
    end

    ////////////////////////////////////////////////////////////////////
    // command registers; address data stable while the toggle settles
    always_ff @(posedge sys_clk) begin
        if (rst || (hostMode && !regRstNS)) begin
            for (int i = 0; i < LSH_REGS; i++)
                regs_q[i] <= LSH_REG_RESET;
        end else if (hostMode && wrTogS != wrTogOld_q
                && wrAddrL_q < 5'(LSH_REGS)) begin
            regs_q[wrAddrL_q[2:0]] <= wrDataL_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration and recovered data
    lsh_cfg_t cfg_q;
    logic [LSH_CHANNELS-1:0] muteVec;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_q <= '0;
        end else begin
            for (int c = 0; c < LSH_CHANNELS; c++) begin
                if (hostMode) begin
                    cfg_q.rxShutoff[c] <= regs_q[c][LSH_BIT_RECEIVER_SHUTOFF];
                    cfg_q.muteEn[c] <= regs_q[c][LSH_BIT_MUTE];
                    cfg_q.clkInvert[c] <= regs_q[c][LSH_BIT_CLKINV];
                    cfg_q.singleRail[c] <= regs_q[c][LSH_BIT_SINGLE];
                end else begin
                    cfg_q.rxShutoff[c] <= rxOffS;
                    cfg_q.muteEn[c] <= muteS;
                    cfg_q.clkInvert[c] <= clkInvS;
                    cfg_q.singleRail[c] <= pinSync[1];
                end
            end
        end
    end

    assign cfgOut = cfg_q;
    assign muteVec = cfg_q.muteEn & rxIn.los;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_pos_data_out <= '0;
            rx_neg_data_out <= '0;
        end else begin
            for (int c = 0; c < LSH_CHANNELS; c++) begin
                if (muteVec[c]) begin
                    rx_pos_data_out[c] <= 1'b0;
                    rx_neg_data_out[c] <= 1'b0;
                end else begin
                    rx_pos_data_out[c] <= rxIn.pos[c];
                    // violation flag on negative output
                    rx_neg_data_out[c] <= cfg_q.singleRail[c]
                        ? rxIn.line_code_violation[c] : rxIn.neg[c];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_lossMuted(int c);
        cfg_q.muteEn[c] && rxIn.los[c];
    endsequence

    chk_mute_pos_low: assert property (@(posedge sys_clk)
        disable iff (rst)
        s_lossMuted(0) |=> !rx_pos_data_out[0] && !rx_neg_data_out[0])
        else $error("muted channel drove data");
    chk_no_mute_pass: assert property (@(posedge sys_clk)
        disable iff (rst)
        !cfg_q.muteEn[0] && !cfg_q.singleRail[0] |=>
        rx_pos_data_out[0] == $past(rxIn.pos[0]))
        else $error("data suppressed without mute");
    chk_host_ignore_mute: assert property (@(posedge sys_clk)
        disable iff (rst)
        hostMode && $stable(hostMode) && !regs_q[0][LSH_BIT_MUTE]
        |=> !cfg_q.muteEn[0])
        else $error("mute pin used in host mode");
    chk_hw_receiver_shutoff: assert property (@(posedge sys_clk)
        disable iff (rst)
        !hostMode |=> cfg_q.rxShutoff == {LSH_CHANNELS{$past(rxOffS)}})
        else $error("receiver shutoff wrong");
    chk_hw_clkinv: assert property (@(posedge sys_clk)
        disable iff (rst)
        !hostMode |=> cfg_q.clkInvert[3] == $past(clkInvS))
        else $error("clock invert wrong");
    chk_reg_reset: assert property (@(posedge sys_clk)
        disable iff (rst)
        hostMode && !regRstNS |=> regs_q[0] == LSH_REG_RESET)
        else $error("register reset failed");
    chk_sdo_idle: assert property (@(posedge serialClk)
        state_q != LSH_DATA |-> sdoEnN_q)
        else $error("output driven outside read");
    chk_hw_lcv: assert property (@(posedge sys_clk)
        disable iff (rst)
        cfg_q.singleRail[1] && !muteVec[1] |=>
        rx_neg_data_out[1] == $past(rxIn.line_code_violation[1]))
        else $error("violation not on negative output");
endmodule : lsh_serial_ctrl
`default_nettype wire

// [pkg/lsh_pkg.sv]
// package for the line interface serial control block
package lsh_pkg;
    localparam int LSH_CHANNELS = 4;
    localparam int LSH_ADDR_W = 5;
    localparam int LSH_DATA_W = 8;
    localparam int LSH_REGS = 8;
    localparam int LSH_FRAME_BITS = 1 + LSH_ADDR_W + LSH_DATA_W;
    localparam int LSH_CNT_W = 4;
    localparam logic [LSH_DATA_W-1:0] LSH_REG_RESET = 8'h00;
    // command register bit positions, per channel register
    localparam int LSH_BIT_RECEIVER_SHUTOFF = 0;
    localparam int LSH_BIT_MUTE = 1;
    localparam int LSH_BIT_CLKINV = 2;
    localparam int LSH_BIT_SINGLE = 3;
    localparam logic LSH_RW_READ = 1'b1;

    typedef struct packed {
        logic [LSH_CHANNELS-1:0] rxShutoff;
        logic [LSH_CHANNELS-1:0] muteEn;
        logic [LSH_CHANNELS-1:0] clkInvert;
        logic [LSH_CHANNELS-1:0] singleRail;
    } lsh_cfg_t;

    typedef struct packed {
        logic [LSH_CHANNELS-1:0] pos;
        logic [LSH_CHANNELS-1:0] neg;
        logic [LSH_CHANNELS-1:0] line_code_violation;
        logic [LSH_CHANNELS-1:0] los;
    } lsh_rx_t;

    typedef struct packed {
        logic valid;
        logic [LSH_ADDR_W-1:0] addr;
        logic [LSH_DATA_W-1:0] data;
    } lsh_wr_t;
endpackage : lsh_pkg

// [logic/lsh_sync2.sv]
// two flip-flop level synchroniser, parameterised width
`timescale 1ns/10ps
`default_nettype none
module lsh_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= INIT;
            dout <= INIT;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : lsh_sync2
`default_nettype wire

// [testbench/lsh_mp_model.sv]
// host processor model driving the serial command port
`timescale 1ns/10ps
`default_nettype none
module lsh_mp_model (
    input wire logic hostMode,
    input wire logic hwRail,
    input wire logic hwRxOff,
    output logic chipSelN,
    output logic serialClk,
    output logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOutEnN
);
    logic csQ = 1'b1;
    logic clkQ = 1'b0;
    logic sdiQ = 1'b0;
    // in hardware mode the shared pins carry static levels
    assign chipSelN = hostMode ? csQ : hwRail;
    assign serialClk = hostMode ? clkQ : hwRxOff;
    assign serialDataIn = sdiQ;
    // one frame, 6 ns serial clock; fewer than 14 bits aborts it
    task automatic xfer(input logic rw, input logic [4:0] addr,
        input logic [7:0] wd, input int bits,
        output logic [7:0] rd, output logic enOk);
        logic [13:0] frame;
        frame = {rw, addr, wd};
        rd = 8'h00;
        enOk = 1'b1;
        csQ = 1'b0;
        for (int i = 0; i < bits; i++) begin
            sdiQ = frame[13-i];
            #3;
            // a released output reads back inverted, exposing late drive
            if (i >= 6)
                rd = {rd[6:0], serialDataOutEnN ? ~serialDataOut
                    : serialDataOut};
            if (serialDataOutEnN !== ~(rw && i >= 6))
                enOk = 1'b0;
            clkQ = 1'b1;
            #3;
            clkQ = 1'b0;
        end
        #3;
        csQ = 1'b1;
        sdiQ = ~sdiQ;
        #12;
    endtask : xfer
endmodule : lsh_mp_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the serial control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import lsh_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b0;
    logic hostMode = 1'b0;
    logic hwRail = 1'b0;
    logic hwRxOff = 1'b0;
    logic mute_on_loss_en = 1'b0;
    logic register_reset_n = 1'b1;
    lsh_rx_t rxIn = '{4'hf, 4'ha, 4'h5, 4'h6};
    wire logic chipSelN, serialClk, serialDataIn, serialDataOut;
    wire logic serialDataOutEnN;
    logic [3:0] rxPos, rxNeg;
    lsh_cfg_t cfgOut, expCfg;
    int fails = 0;
    int samplesChecked = 0;
    int cycles = 0;
    logic [7:0] vals [4] = '{8'ha9, 8'h32, 8'hc4, 8'h0f};

    always #10 sys_clk = ~sys_clk;

    lsh_serial_ctrl dut_u (.sys_clk(sys_clk), .rst(rst),
        .hostMode(hostMode), .chipSelN(chipSelN), .serialClk(serialClk),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOutEnN(serialDataOutEnN),
        .mute_on_loss_en(mute_on_loss_en),
        .register_reset_n(register_reset_n), .rxIn(rxIn),
        .rx_pos_data_out(rxPos), .rx_neg_data_out(rxNeg), .cfgOut(cfgOut));
    lsh_mp_model mp_u (.hostMode(hostMode), .hwRail(hwRail),
        .hwRxOff(hwRxOff), .chipSelN(chipSelN), .serialClk(serialClk),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOutEnN(serialDataOutEnN));

    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic pins(input logic h, m, rail, off, rr);
        @(posedge sys_clk);
        hostMode <= h;
        mute_on_loss_en <= m;
        hwRail <= rail;
        hwRxOff <= off;
        register_reset_n <= rr;
        repeat (10) @(posedge sys_clk);
    endtask : pins

    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        mp_u.xfer(1'b1, a, 8'h00, 14, d, ok);
        check("read data", {8'h00, exp}, {8'h00, d});
        check("sdo enable in read", 16'h0001, {15'h0000, ok});
        check("sdo released", 16'h0001, {15'h0000, serialDataOutEnN});
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [7:0] v, input int n);
        logic [7:0] d;
        logic ok;
        mp_u.xfer(1'b0, a, v, n, d, ok);
        check("sdo enable in write", 16'h0001, {15'h0000, ok});
    endtask : wr

    ////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        // a real rising edge, so the link-side flops see reset too
        rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        check("hw cfg a", 16'hfff0, cfgOut);
        check("hw muted rx", 16'h0098, {8'h00, rxPos, rxNeg});
        pins(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        check("hw cfg b", 16'h000f, cfgOut);
        check("hw rx", 16'h00f5, {8'h00, rxPos, rxNeg});
        pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        check("host cfg", 16'h0000, cfgOut);
        check("host rx", 16'h00fa, {8'h00, rxPos, rxNeg});
        expCfg = '0;
        for (int c = 0; c < 4; c++) begin
            wr(c[4:0], vals[c], 14);
            expCfg.rxShutoff[c] = vals[c][LSH_BIT_RECEIVER_SHUTOFF];
            expCfg.muteEn[c] = vals[c][LSH_BIT_MUTE];
            expCfg.clkInvert[c] = vals[c][LSH_BIT_CLKINV];
            expCfg.singleRail[c] = vals[c][LSH_BIT_SINGLE];
        end
        wr(5'h07, 8'h5a, 14);
        wr(5'h08, 8'hff, 14);
        wr(5'h00, 8'h00, 9);
        repeat (10) @(posedge sys_clk);
        check("host cfg written", expCfg, cfgOut);
        for (int c = 0; c < 4; c++) begin
            rd(c[4:0], vals[c]);
        end
        rd(5'h07, 8'h5a);
        pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        check("reg reset cfg", 16'h0000, cfgOut);
        pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        rd(5'h07, LSH_REG_RESET);
        rd(5'h00, LSH_REG_RESET);
        conclude();
    end
endmodule : testbench
`default_nettype wire
